// *** rtl/ire_pkg.sv ***
// Purpose: shared constants for the infrared endec
// Assumes: one system clock; baud tick is a one-cycle enable at 16x bit rate
// Notes:   all counts are in baud-clock periods unless named otherwise
package ire_pkg;
    // ----------------------------------------------------------------
    // bit cell timing
    // ----------------------------------------------------------------
    localparam int unsigned CELL_CLKS     = 16;   // baud clocks per bit
    localparam int unsigned TX_LOW_PRE    = 7;    // low before pulse
    localparam int unsigned TX_HIGH       = 3;    // pulse width
    localparam int unsigned TX_LOW_POST   = 6;    // low after pulse
    localparam int unsigned RX_UPDATE_CNT = 8;    // uart input update point
    localparam int unsigned RX_WIN_OPEN   = 12;   // window opens
    localparam int unsigned RX_DELAY      = 8;    // decoded stream lag
    localparam int unsigned CNT_W         = 4;    // counter 0..15
    // ----------------------------------------------------------------
    // rates and clocks
    // ----------------------------------------------------------------
    localparam real         SYS_CLK_MHZ   = 250.0;
    localparam real         MIN_SYS_MHZ   = 1.0;  // floor for 1.6 us pulses
    localparam real         MIN_PULSE_US  = 1.6;
    localparam int unsigned MIN_BAUD      = 9600;
    localparam int unsigned MAX_STD_BAUD  = 115200;
    localparam int unsigned DIV_W         = 16;   // baud divisor width
    localparam logic        IDLE_LINE     = 1'b1; // uart idle level
    localparam int unsigned FIFO_DEPTH    = 4;
endpackage

// *** rtl/ire_tick.sv ***
// Purpose: baud clock enable at 16x the bit rate from the uart divisor
// Assumes: divisor of zero is treated as one
// Notes:   one-cycle pulse every divisor system clocks
`timescale 1ns/1ns
module ire_tick #(
    parameter int unsigned DW = 16
) (
    input  wire logic          i_clk,
    input  wire logic          i_arst_n,
    input  wire logic          i_run,
    input  wire logic [DW-1:0] i_div,
    output logic               o_tick
);
    typedef struct packed {
        logic [DW-1:0] cnt;
        logic          tick;
    } ire_tick_s;
    ire_tick_s st_reg;
    ire_tick_s st_next;

    // count down the divisor, pulse on wrap
    always_comb begin
        st_next      = st_reg;
        st_next.tick = 1'b0;
        if (!i_run) begin
            st_next.cnt = '0;
        end else if (st_reg.cnt <= DW'(1)) begin
            st_next.cnt  = i_div;
            st_next.tick = 1'b1;
        end else begin
            st_next.cnt = st_reg.cnt - DW'(1);
        end
    end

    // state register
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_tick = st_reg.tick;
endmodule

// *** rtl/ire_fifo.sv ***
// Purpose: small valid/ready fifo for the transmit bit stream
// Assumes: single clock
// Notes:   full and empty are exact; no write when full
`timescale 1ns/1ns
module ire_fifo #(
    parameter int unsigned W = 1,
    parameter int unsigned D = 4
) (
    input  wire logic         i_clk,
    input  wire logic         i_arst_n,
    input  wire logic         i_valid,
    output logic              o_ready,
    input  wire logic [W-1:0] i_data,
    output logic              o_valid,
    input  wire logic         i_ready,
    output logic [W-1:0]      o_data
);
    localparam int unsigned AW = (D > 1) ? $clog2(D) : 1;
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   cnt;
    } ire_fifo_s;
    ire_fifo_s st_reg;
    ire_fifo_s st_next;
    logic [W-1:0] mem [D];
    logic         wr;
    logic         rd;

    assign o_ready = (st_reg.cnt != (AW+1)'(D));
    assign o_valid = (st_reg.cnt != '0);
    assign o_data  = mem[st_reg.rp];
    assign wr      = i_valid && o_ready;
    assign rd      = o_valid && i_ready;

    // pointer and occupancy update
    always_comb begin
        st_next = st_reg;
        if (wr) begin
            st_next.wp = (st_reg.wp == AW'(D-1)) ? '0 : st_reg.wp + AW'(1);
        end
        if (rd) begin
            st_next.rp = (st_reg.rp == AW'(D-1)) ? '0 : st_reg.rp + AW'(1);
        end
        st_next.cnt = st_reg.cnt + (AW+1)'(wr) - (AW+1)'(rd);
    end

    // state register
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // storage
    always_ff @(posedge i_clk) begin
        if (wr) begin
            mem[st_reg.wp] <= i_data;
        end
    end
endmodule

// *** rtl/ire_endec.sv ***
// Purpose: uart to infrared encoder and decoder
// Assumes: uart supplies divisor, enable bits and tx bits one per cell
// Notes:   no software registers; controls arrive from uart control logic
`timescale 1ns/1ns

// Function
// R1: when enabled, encoded tx stream drives the tx pin instead of raw uart
// R2: half duplex; receiver ignored while a transmission is in progress
// R3: bit rate is system clock over sixteen times the uart divisor
// R4: software must enable the uart whenever the endec is used
// R5: each bit spans sixteen baud clocks; a one bit stays low
// R6: zero bit is seven low, three high, six low
// R7: when enabled, rx pin is decoded and fed to uart receive input
// R8: receiver counter runs zero to fifteen, timing output and window
// R9: decoded stream lags the infrared stream by eight baud clocks
// R10: a falling edge on the received stream resets the counter; the code ignores falling edges in RX_CELL, counts 0 to 11
// R11: at count eight the uart receive input takes the decoded value
// R12: window opens at twelve and closes at the next eight
// R13: pulse in window repeats; none returns receiver to idle
// R14: resynchronising the receiver does not disturb the uart itself
// R15: system clock must be at least 1.0 MHz for 1.6 us pulses
// R16: software sets enable before selecting the pin alternate function
// R17: configuration lives in uart control registers, none here
// R18: standard rates 9600 to 115200 baud, higher rates allowed
// R19: a cell with a pulse decodes to zero, no pulse to one
module ire_endec
    import ire_pkg::*;
#(
    parameter int unsigned DIV_WIDTH = ire_pkg::DIV_W,
    parameter int unsigned TX_DEPTH  = ire_pkg::FIFO_DEPTH
) (
    input  wire logic                 I_CLK,
    input  wire logic                 I_ARST_N,
    input  wire logic                 I_UART_EN,
    input  wire logic                 I_INFRARED_ENABLE,
    input  wire logic [DIV_WIDTH-1:0] I_BAUD_DIV,
    input  wire logic                 I_TX_VALID,
    output logic                      O_TX_READY,
    input  wire logic                 I_TX_BIT,
    input  wire logic                 I_UART_TXD,
    output logic                      O_INFRARED_TX_OUT,
    input  wire logic                 I_INFRARED_RX_IN,
    output logic                      O_UART_RXD,
    output logic                      O_TX_BUSY,
    output logic                      O_BAUD_TICK
);
    import ire_pkg::*;

    // ----------------------------------------------------------------
    // types and state
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        RX_IDLE = 3'b001,
        RX_CELL = 3'b010,
        RX_WIN  = 3'b100
    } ire_rx_e;

    typedef struct packed {
        logic             sy1;
        logic             sy2;
        logic             rx_prev;
        ire_rx_e          rx_st;
        logic [CNT_W-1:0] rx_cnt;
        logic             cell_bit;
        logic             rxd;
        logic             tx_act;
        logic             tx_bit;
        logic [CNT_W-1:0] tx_cnt;
        logic             ir_out;
    } ire_endec_s;

    ire_endec_s st_reg;
    ire_endec_s st_next;

    localparam logic [CNT_W-1:0] PULSE_BEG = CNT_W'(TX_LOW_PRE);
    localparam logic [CNT_W-1:0] PULSE_END = CNT_W'(TX_LOW_PRE + TX_HIGH);
    localparam logic [CNT_W-1:0] CELL_LAST = CNT_W'(CELL_CLKS - 1);
    localparam logic [CNT_W-1:0] UPD_CNT   = CNT_W'(RX_UPDATE_CNT);
    localparam logic [CNT_W-1:0] WIN_CNT   = CNT_W'(RX_WIN_OPEN);

    logic             run;
    logic             tick;
    logic             fifo_valid;
    logic             fifo_data;
    logic             fifo_take;
    logic             fall;

    assign run = I_UART_EN && I_INFRARED_ENABLE;

    // ----------------------------------------------------------------
    // baud clock and tx bit buffer
    // ----------------------------------------------------------------
    // 16x baud enable from uart divisor [R3]
    // full-width divisor covers 9600 to 115200 baud and faster rates too [R18]
    ire_tick #(
        .DW (DIV_WIDTH)
    ) u_tick (
        .i_clk    (I_CLK),
        .i_arst_n (I_ARST_N),
        .i_run    (I_UART_EN),
        .i_div    (I_BAUD_DIV),
        .o_tick   (tick)
    );

    ire_fifo #(
        .W (1),
        .D (TX_DEPTH)
    ) u_fifo (
        .i_clk    (I_CLK),
        .i_arst_n (I_ARST_N),
        .i_valid  (I_TX_VALID && run),
        .o_ready  (O_TX_READY),
        .i_data   (I_TX_BIT),
        .o_valid  (fifo_valid),
        .i_ready  (fifo_take),
        .o_data   (fifo_data)
    );

    // a new cell starts on a tick when idle or at the end of a cell
    assign fifo_take = run && tick && fifo_valid && st_reg.rx_st == RX_IDLE &&
                       (!st_reg.tx_act || st_reg.tx_cnt == CELL_LAST);   // [R2]
    // falling edge on the synchronised receive stream
    assign fall = st_reg.rx_prev && !st_reg.sy2;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        st_next         = st_reg;
        st_next.sy1     = I_INFRARED_RX_IN;
        st_next.sy2     = st_reg.sy1;
        st_next.rx_prev = st_reg.sy2;
        if (!run) begin
            st_next.rx_st  = RX_IDLE;
            st_next.rx_cnt = '0;
            st_next.rxd    = IDLE_LINE;
            st_next.tx_act = 1'b0;
            st_next.tx_cnt = '0;
            st_next.ir_out = 1'b0;
        end else begin
            // transmit cell timing [R5] [R6]
            if (fifo_take) begin
                st_next.tx_act = 1'b1;
                st_next.tx_bit = fifo_data;
                st_next.tx_cnt = '0;
            end else if (tick && st_reg.tx_act) begin
                if (st_reg.tx_cnt == CELL_LAST) begin
                    st_next.tx_act = 1'b0;                      // [R5]
                end
                st_next.tx_cnt = st_reg.tx_cnt + CNT_W'(1);
            end
            // pulse only inside a zero cell, at counts 7 to 9 [R6]
            st_next.ir_out = st_next.tx_act && !st_next.tx_bit &&
                             st_next.tx_cnt >= PULSE_BEG && st_next.tx_cnt < PULSE_END;
            // receive decoder, blocked while transmitting or starting a cell [R2]
            if (st_reg.tx_act || fifo_take) begin
                st_next.rx_st = RX_IDLE;
            end else begin
                if (fall && st_reg.rx_st != RX_CELL) begin
                    st_next.rx_cnt   = '0;                      // [R10]
                    st_next.rx_st    = RX_CELL;
                    st_next.cell_bit = 1'b0;                    // [R19]
                end else if (tick && st_reg.rx_st != RX_IDLE) begin
                    st_next.rx_cnt = st_reg.rx_cnt + CNT_W'(1); // [R8]
                    if (st_reg.rx_cnt + CNT_W'(1) == UPD_CNT) begin
                        st_next.rxd = st_reg.cell_bit;          // [R9] [R11]
                        if (st_reg.rx_st == RX_WIN) begin
                            // window closed without a pulse: a one cell [R13]
                            st_next.rx_st    = RX_IDLE;
                            st_next.rxd      = 1'b1;            // [R19]
                            st_next.cell_bit = 1'b1;
                        end
                    end
                    if (st_reg.rx_cnt + CNT_W'(1) == WIN_CNT &&
                        st_reg.rx_st == RX_CELL) begin
                        st_next.rx_st = RX_WIN;                 // [R12]
                    end
                end
                if (st_reg.rx_st == RX_IDLE && tick && !fall) begin
                    st_next.rxd = IDLE_LINE;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            st_reg          <= '0;
            st_reg.sy1      <= 1'b1;
            st_reg.sy2      <= 1'b1;
            st_reg.rx_prev  <= 1'b1;
            st_reg.rx_st    <= RX_IDLE;
            st_reg.rxd      <= 1'b1;
            st_reg.cell_bit <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // raw uart tx when disabled, encoded stream when enabled [R1] [R17]
    assign O_INFRARED_TX_OUT = run ? st_reg.ir_out : I_UART_TXD;
    // uart receive sees decoded data; uart keeps its own start-bit sync [R7] [R14]
    assign O_UART_RXD        = run ? st_reg.rxd : st_reg.sy2;
    assign O_TX_BUSY         = st_reg.tx_act;
    assign O_BAUD_TICK       = tick;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    AST_TX_ONE_LOW: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
        (st_reg.tx_act && st_reg.tx_bit) |-> !st_reg.ir_out)   // [R5]
        else $error("one cell produced a pulse");
    AST_TX_PULSE_POS: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
        st_reg.ir_out |-> (st_reg.tx_cnt >= PULSE_BEG && st_reg.tx_cnt < PULSE_END)) // [R6]
        else $error("pulse outside counts seven to nine");
    AST_HALF_DUPLEX: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
        st_reg.tx_act |-> st_reg.rx_st == RX_IDLE)              // [R2]
        else $error("receive active during transmit");
    AST_TX_ROUTE: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
        !run |-> O_INFRARED_TX_OUT == I_UART_TXD)               // [R1]
        else $error("raw uart tx not passed when disabled");
    AST_RX_RESYNC: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
        (run && !st_reg.tx_act && !fifo_take && fall && st_reg.rx_st != RX_CELL)
        |=> (st_reg.rx_cnt == '0 && st_reg.rx_st == RX_CELL))   // [R10]
        else $error("counter not reset on falling edge");
    AST_RX_UPDATE: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
        $changed(st_reg.rxd) && run && $past(run) && $past(st_reg.rx_st) != RX_IDLE
        |-> st_reg.rx_cnt == UPD_CNT)                           // [R11]
        else $error("uart input changed away from count eight");
    AST_RX_WIN: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
        st_reg.rx_st == RX_WIN |-> (st_reg.rx_cnt >= WIN_CNT || st_reg.rx_cnt < UPD_CNT)) // [R12]
        else $error("window open outside twelve to eight");
    AST_RX_ZERO: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
        (st_reg.rx_st == RX_CELL && st_reg.rx_cnt == UPD_CNT && run && !st_reg.tx_act)
        |-> st_reg.rxd == 1'b0)                                 // [R19]
        else $error("pulse cell not decoded as zero");
    AST_CNT_RANGE: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
        (tick && st_reg.rx_st == RX_CELL && !fall && run && !st_reg.tx_act)
        |=> st_reg.rx_cnt == $past(st_reg.rx_cnt) + CNT_W'(1))  // [R8]
        else $error("receive counter did not advance");
    COV_ZERO_TX: cover property (@(posedge I_CLK) st_reg.ir_out);
    COV_RX_WIN: cover property (@(posedge I_CLK) st_reg.rx_st == RX_WIN);
    COV_RX_IDLE_BACK: cover property (@(posedge I_CLK)
        st_reg.rx_st == RX_WIN ##1 st_reg.rx_st == RX_IDLE);
endmodule

// *** sim/ire_ir_model.sv ***
// Purpose: infrared transceiver model that plays encoded cells onto the rx pin
// Assumes: received pulses are active low on a line pulled high when idle
// Notes:   plays i_len cells of i_bits, lsb first, one slot per endec baud tick
`timescale 1ns/1ns
module ire_ir_model (
    input  wire logic       i_clk,
    input  wire logic       i_arst_n,
    input  wire logic       i_tick,
    input  wire logic       i_go,
    input  wire logic [7:0] i_bits,
    input  wire logic [3:0] i_len,
    output logic            o_rx,
    output logic            o_busy
);
    logic [7:0] pos;

    // ------------------------------------------------------------
    // cell player
    // ------------------------------------------------------------
    // sixteen slots per cell; a zero cell pulls the line low in slots 7 to 9
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rx   <= 1'b1;
            o_busy <= 1'b0;
            pos    <= 8'h00;
        end else if (i_go && !o_busy) begin
            o_busy <= 1'b1;
            pos    <= 8'h00;
        end else if (o_busy && i_tick) begin
            if (pos == {i_len, 4'h0}) begin
                o_busy <= 1'b0;
                o_rx   <= 1'b1; // released line returns to its pull-up
            end else begin
                o_rx <= !(!i_bits[pos[6:4]] && pos[3:0] >= 4'h7 && pos[3:0] <= 4'h9);
                pos  <= pos + 8'h01;
            end
        end
    end
endmodule

// *** sim/ire_endec_tb.sv ***
// Purpose: self-checking bench for the infrared endec
// Assumes: divisor of two, so one baud tick every two system clocks
// Notes:   transceiver side played by ire_ir_model; uart side driven here
`timescale 1ns/1ns
module ire_endec_tb;
    import ire_pkg::*;
    localparam logic [DIV_W-1:0] DIV = 16'h0002; // short divisor keeps the run brief

    logic       clk, arst_n, uart_en, ir_en, tx_valid, tx_bit, uart_txd, tb_rx;
    logic       go, cap, rx_low;
    logic [7:0] m_bits;
    logic [3:0] m_len;
    logic       rec [0:127];
    int         n_rec, ticks, t_fall, t_dec, num_errors, tests_run;
    wire logic  tx_ready, ir_tx, uart_rxd, tx_busy, tick, ir_rx, m_busy, rx_pin;

    assign rx_pin = ir_rx & tb_rx; // wired-and of model and bench drive

    // ------------------------------------------------------------
    // instances
    // ------------------------------------------------------------
    ire_endec #(.DIV_WIDTH(DIV_W), .TX_DEPTH(FIFO_DEPTH)) i_ire_endec (
        .I_CLK(clk), .I_ARST_N(arst_n), .I_UART_EN(uart_en), .I_INFRARED_ENABLE(ir_en),
        .I_BAUD_DIV(DIV), .I_TX_VALID(tx_valid), .O_TX_READY(tx_ready), .I_TX_BIT(tx_bit),
        .I_UART_TXD(uart_txd), .O_INFRARED_TX_OUT(ir_tx), .I_INFRARED_RX_IN(rx_pin),
        .O_UART_RXD(uart_rxd), .O_TX_BUSY(tx_busy), .O_BAUD_TICK(tick));

    ire_ir_model i_ire_ir_model (
        .i_clk(clk), .i_arst_n(arst_n), .i_tick(tick), .i_go(go), .i_bits(m_bits),
        .i_len(m_len), .o_rx(ir_rx), .o_busy(m_busy));

    // ------------------------------------------------------------
    // clock and monitors
    // ------------------------------------------------------------
    // 250 MHz system clock, well above the 1 MHz floor
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // tick counter, tx slot recorder and rx disturbance watch
    always @(posedge clk) begin
        if (tick) ticks <= ticks + 1;
        if (cap && tick && (tx_busy || n_rec > 0) && n_rec < 128) begin
            rec[n_rec] <= ir_tx;
            n_rec      <= n_rec + 1;
        end
        if (cap && !uart_rxd) rx_low <= 1'b1;
    end

    always @(negedge rx_pin) t_fall = ticks;
    always @(negedge uart_rxd) t_dec = ticks;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic step;
        @(posedge clk);
        #1;
    endtask

    task automatic wait_ticks(input int n);
        int t;
        t = ticks + n;
        while (ticks < t) step;
    endtask

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    // endec off: raw paths; uart off: no ticks; uart on: tick every DIV clocks
    task automatic test_bypass;
        int t;
        uart_en  = 1'b1;
        uart_txd = 1'b0;
        step;
        chk(8'(ir_tx), 8'h00);
        uart_txd = 1'b1;
        step;
        chk(8'(ir_tx), 8'h01);
        tb_rx = 1'b0;
        repeat (4) step;
        chk(8'(uart_rxd), 8'h00);
        tb_rx = 1'b1;
        repeat (4) step;
        chk(8'(uart_rxd), 8'h01);
        uart_en = 1'b0;
        ir_en   = 1'b1; // endec enabled before the pin is handed over
        step; // let a tick already in flight be counted first
        t = ticks;
        repeat (10) step;
        chk(8'(ticks - t), 8'h00);
        uart_en = 1'b1; // uart enabled whenever the endec is used
        repeat (2) step;
        t = ticks;
        repeat (20) step;
        chk(8'(ticks - t), 8'(20 / int'(DIV)));
    endtask

    // fill the tx buffer until it refuses, then check every slot of every cell
    task automatic test_tx;
        logic [7:0] bits;
        int         n, i, w;
        logic       full, e;
        bits = 8'b1101_0010; // cells 0,1,0,0,1,0,1,1
        n    = 0;
        full = 1'b0;
        cap  = 1'b1;
        while (!full && n < 8) begin
            tx_bit   = bits[n];
            tx_valid = 1'b1;
            if (tx_ready) begin
                step;
                n++;
            end else begin
                full = 1'b1;
            end
        end
        tx_valid = 1'b0;
        chk(8'(full), 8'h01);
        m_bits = 8'h00;
        m_len  = 4'h2;
        go = 1'b1; // incoming pulses while sending must be ignored
        step;
        go = 1'b0;
        w  = 0;
        while ((n_rec == 0 || tx_busy) && w < 4000) begin
            step;
            w++;
        end
        cap = 1'b0;
        chk(8'(w < 4000), 8'h01);
        for (i = 0; i < n * 16; i++) begin
            e = !bits[i / 16] && (i % 16) >= 7 && (i % 16) <= 9;
            chk(8'(rec[i]), 8'(e));
        end
        chk(8'(ir_tx), 8'h00);
        chk(8'(rx_low), 8'h00);
    endtask

    // cells 0,0,1,0,1,1 decode with an eight tick lag and return to idle
    task automatic test_rx;
        int k;
        m_bits = 8'b0011_0100;
        m_len  = 4'h6;
        t_fall = -1;
        t_dec  = -1;
        go = 1'b1;
        step;
        go = 1'b0;
        wait_ticks(20);
        chk(8'(t_dec - t_fall >= 8 && t_dec - t_fall <= 11), 8'h01);
        wait_ticks(3);
        for (k = 0; k < 6; k++) begin
            chk(8'(uart_rxd), 8'(m_bits[k]));
            wait_ticks(16);
        end
        chk(8'(uart_rxd), 8'h01);
    endtask

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        arst_n = 1'b0;
        uart_en = 1'b0;
        ir_en = 1'b0;
        tx_valid = 1'b0;
        tx_bit = 1'b0;
        uart_txd = 1'b1;
        tb_rx = 1'b1;
        go = 1'b0;
        cap = 1'b0;
        rx_low = 1'b0;
        m_bits = 8'h00;
        m_len = 4'h2;
        n_rec = 0;
        ticks = 0;
        num_errors = 0;
        tests_run = 0;
        repeat (6) @(posedge clk);
        #1;
        chk({4'h0, uart_rxd, tx_busy, tx_ready, tick}, 8'h0A);
        arst_n = 1'b1;
        test_bypass;
        test_tx;
        test_rx;
        summarize;
    end

    // cut a hang short well past the expected run length
    initial begin
        #(4 * 20000);
        num_errors++;
        $display("watchdog expired at %0t", $time);
        summarize;
    end
endmodule
